// ===== verif/dmarc_channel_tb_top.sv
// dmarc_channel_tb_top: self-checking bench for one dma channel
`timescale 1ns/1ps
`default_nettype none

module dmarc_channel_tb_top;
  import dmarc_pkg::*;
  logic clk;
  logic rst;
  dmarc_regreq_t reg_req;
  logic [31:0] reg_rdata;
  logic hw_request_line;
  logic debug_halt;
  logic other_channels_on;
  logic slow;
  dmarc_memrsp_t mem_rsp;
  dmarc_memreq_t mem_out;
  logic mem_hold;
  logic channel_busy;
  logic chan_irq;
  logic dma_clk_en;
  logic [23:0] last_addr;
  logic [15:0] last_wdata;
  logic last_we;
  logic last_word;
  logic [15:0] xfer_count;
  logic [15:0] d;
  logic [31:0] rd_val;
  logic [31:0] w;
  logic [31:0] v;
  logic [23:0] a2;
  logic [23:0] b2;
  logic [23:0] exp_b;
  dmarc_ctrl_t c;
  int errors;
  int tests_run;
  integer seed;

  dmarc_channel dmarc_channel_inst (.clk(clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .hw_request_line(hw_request_line), .debug_halt(debug_halt),
    .other_channels_on(other_channels_on), .mem_rsp(mem_rsp), .mem_out(mem_out),
    .mem_hold(mem_hold), .channel_busy(channel_busy), .chan_irq(chan_irq),
    .dma_clk_en(dma_clk_en));
  dmarc_mem_model dmarc_mem_model_inst (.clk(clk), .rst(rst), .slow(slow),
    .mem_out(mem_out), .mem_rsp(mem_rsp), .last_addr(last_addr), .last_wdata(last_wdata),
    .last_we(last_we), .last_word(last_word), .xfer_count(xfer_count));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [23:0] stepped(input logic [23:0] a, input logic [1:0] k);
    case (k)
      2'h0: return a + 24'h1;
      2'h1: return a + 24'h2;
      2'h2: return a - 24'h1;
      default: return a - 24'h2;
    endcase
  endfunction : stepped

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: x, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req.wr <= 1'b0;
    #1;
  endtask : reg_wr

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1 rd_val = reg_rdata;
    chk_val(rd_val, exp);
  endtask : chk_reg

  task automatic wait_idle;
    int n;
    n = 0;
    while (channel_busy !== 1'b0 && n < 4000)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk_bit(channel_busy, 1'b0);
  endtask : wait_idle

  task automatic wait_cnt(input logic [15:0] t);
    int n;
    n = 0;
    while (xfer_count !== t && n < 4000)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk_val({16'h0, xfer_count}, {16'h0, t});
  endtask : wait_cnt

  task automatic report_and_stop;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    #300000;
    errors++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    report_and_stop();
  end

  initial
  begin
    seed = 98204;
    errors = 0;
    tests_run = 0;
    rst = 1'b1;
    reg_req = '0;
    hw_request_line = 1'b0;
    debug_halt = 1'b0;
    other_channels_on = 1'b0;
    slow = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    chk_reg(DMARC_OFS_CTRL, 32'h0);
    chk_reg(DMARC_OFS_STAT, 32'h0);
    chk_reg(8'h18, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      w = $random(seed);
      reg_wr(8'(i * 4), w);
      chk_reg(8'(i * 4), {8'h00, w[23:0]});
    end
    reg_wr(DMARC_OFS_L_RLD, 32'h3);
    chk_reg(DMARC_OFS_STAT, 32'h8);
    reg_wr(DMARC_OFS_STAT, 32'h0);
    chk_reg(DMARC_OFS_STAT, 32'h8);
    reg_wr(DMARC_OFS_STAT, 32'h8);
    chk_reg(DMARC_OFS_STAT, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 8; i++)
    begin
      w = $random(seed);
      v = $random(seed);
      c = dmarc_ctrl_t'({1'b0, ~i[1:0], i[0], i[1:0], 1'b1, 1'b1, 1'b0, 1'b0, w[2], i[2],
        w[3], w[1], w[0], 1'b1});
      slow = i[0];
      @(posedge clk);
      other_channels_on <= w[4];
      reg_wr(DMARC_OFS_A_CNT, {8'h00, w[31:8]});
      reg_wr(DMARC_OFS_B_CNT, {8'h00, v[23:0]});
      reg_wr(DMARC_OFS_L_CNT, 32'h2);
      reg_wr(DMARC_OFS_CTRL, {16'h0, c});
      chk_bit(dma_clk_en, 1'b1);
      chk_bit(mem_hold, 1'b0);
      wait_idle();
      a2 = stepped(w[31:8], i[1:0]);
      b2 = i[0] ? stepped(v[23:0], ~i[1:0]) : v[23:0];
      exp_b = (i[2] && i[0]) ? stepped(b2, ~i[1:0]) : v[23:0];
      chk_reg(DMARC_OFS_A_CNT, {8'h00, stepped(a2, i[1:0])});
      chk_reg(DMARC_OFS_B_CNT, {8'h00, exp_b});
      chk_reg(DMARC_OFS_L_CNT, 32'h0);
      chk_reg(DMARC_OFS_STAT, 32'h3);
      chk_bit(chan_irq, w[0] | w[1]);
      chk_bit(last_word, w[3]);
      chk_bit(last_we, i[2] | w[2]);
      chk_val({8'h00, last_addr}, {8'h00, (i[2] && !w[2]) ? b2 : a2});
      if (i[2])
        chk_val({24'h0, last_wdata[7:0]}, {24'h0, (w[2] ? b2[15:8] : a2[15:8])});
      c.soft_request = 1'b0;
      reg_wr(DMARC_OFS_CTRL, {16'h0, c});
      chk_bit(channel_busy, 1'b1);
      reg_wr(DMARC_OFS_CTRL, 32'h0);
      reg_wr(DMARC_OFS_STAT, 32'hB);
      chk_bit(chan_irq, 1'b0);
      chk_bit(dma_clk_en, w[4]);
    end
    $display("test transfers done");
    @(posedge clk);
    debug_halt <= 1'b1;
    d = xfer_count;
    reg_wr(DMARC_OFS_L_CNT, 32'h0);
    reg_wr(DMARC_OFS_CTRL, 32'h101);
    chk_reg(DMARC_OFS_L_CNT, 32'hFFFF);
    repeat (10) @(posedge clk);
    chk_val({16'h0, xfer_count}, {16'h0, d});
    @(posedge clk);
    debug_halt <= 1'b0;
    wait_cnt(d + 16'h1);
    reg_wr(DMARC_OFS_CTRL, 32'h0);
    chk_bit(channel_busy, 1'b0);
    repeat (8) @(posedge clk);
    $display("test halt done");
    w = $random(seed);
    reg_wr(DMARC_OFS_L_CNT, 32'h1);
    reg_wr(DMARC_OFS_A_RLD, w);
    reg_wr(DMARC_OFS_L_RLD, 32'h1);
    d = xfer_count;
    reg_wr(DMARC_OFS_CTRL, 32'h1);
    @(posedge clk);
    hw_request_line <= 1'b1;
    wait_cnt(d + 16'h1);
    @(posedge clk);
    hw_request_line <= 1'b0;
    chk_reg(DMARC_OFS_STAT, 32'h5);
    chk_reg(DMARC_OFS_A_CNT, {8'h00, w[23:0]});
    @(posedge clk);
    hw_request_line <= 1'b1;
    wait_idle();
    @(posedge clk);
    hw_request_line <= 1'b0;
    chk_reg(DMARC_OFS_STAT, 32'h3);
    reg_wr(DMARC_OFS_CTRL, 32'h0);
    $display("test double buffer done");
    reg_wr(DMARC_OFS_L_CNT, 32'h1);
    reg_wr(DMARC_OFS_L_RLD, 32'h1);
    reg_wr(DMARC_OFS_STAT, 32'hB);
    d = xfer_count;
    reg_wr(DMARC_OFS_CTRL, 32'h1C1);
    chk_bit(mem_hold, 1'b1);
    wait_cnt(d + 16'h3);
    chk_bit(channel_busy, 1'b1);
    reg_wr(DMARC_OFS_CTRL, 32'h0);
    chk_reg(DMARC_OFS_STAT, 32'h3);
    $display("test auto init done");
    report_and_stop();
  end
endmodule : dmarc_channel_tb_top

`default_nettype wire

// ===== verif/dmarc_mem_model.sv
// dmarc_mem_model: memory bus partner answering the channel's transactions
`timescale 1ns/1ps
`default_nettype none

module dmarc_mem_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire dmarc_pkg::dmarc_memreq_t mem_out,
  output dmarc_pkg::dmarc_memrsp_t mem_rsp,
  output logic [23:0] last_addr,
  output logic [15:0] last_wdata,
  output logic last_we,
  output logic last_word,
  output logic [15:0] xfer_count
);
  import dmarc_pkg::*;
  logic ack_q;
  logic [1:0] wait_q;
  logic [15:0] rdat_q;

  // one ack per request; read data churns outside the ack cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ack_q <= 1'b0;
      wait_q <= 2'h0;
      rdat_q <= 16'hA5C3;
      xfer_count <= 16'h0000;
      last_addr <= 24'h000000;
      last_wdata <= 16'h0000;
      last_we <= 1'b0;
      last_word <= 1'b0;
    end
    else if (!ack_q && mem_out.req && wait_q == (slow ? 2'h3 : 2'h0))
    begin
      ack_q <= 1'b1;
      wait_q <= 2'h0;
      rdat_q <= {mem_out.addr[7:0] ^ 8'h5A, mem_out.addr[15:8]};
      xfer_count <= xfer_count + 16'h0001;
      last_addr <= mem_out.addr;
      last_we <= mem_out.we;
      last_word <= mem_out.word;
      if (mem_out.we)
        last_wdata <= mem_out.wdata;
    end
    else
    begin
      ack_q <= 1'b0;
      rdat_q <= ~rdat_q;
      if (!ack_q && mem_out.req)
        wait_q <= wait_q + 2'h1;
    end
  end

  assign mem_rsp = '{ack: ack_q, rdata: rdat_q};
endmodule : dmarc_mem_model

`default_nettype wire

// ===== verilog/dmarc_channel.sv
// dmarc_channel: one dma channel with register file, transfer engine and flags
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module dmarc_channel
(
  input wire logic clk,
  input wire logic rst,
  input wire dmarc_pkg::dmarc_regreq_t reg_req,
  output logic [31:0] reg_rdata,
  input wire logic hw_request_line,
  input wire logic debug_halt,
  input wire logic other_channels_on,
  input wire dmarc_pkg::dmarc_memrsp_t mem_rsp,
  output dmarc_pkg::dmarc_memreq_t mem_out,
  output logic mem_hold,
  output logic channel_busy,
  output logic chan_irq,
  output logic dma_clk_en
);
  import dmarc_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [23:0] step_addr(input logic [23:0] a, input logic en,
                                            input logic [1:0] code);
    logic [23:0] r;
    r = a;
    if (en)
    begin
      unique case (code)
        DMARC_STEP_INC1: r = a + 24'h000001;
        DMARC_STEP_INC2: r = a + 24'h000002;
        DMARC_STEP_DEC1: r = a - 24'h000001;
        DMARC_STEP_DEC2: r = a - 24'h000002;
      endcase
    end
    return r;
  endfunction : step_addr

  function automatic logic [15:0] len_load(input logic [15:0] v);
    return (v == 16'h0000) ? DMARC_LEN_ZERO_AS : v;
  endfunction : len_load

  function automatic logic reg_hit(input dmarc_regreq_t r, input logic [7:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction : reg_hit

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  dmarc_state_t q;
  dmarc_state_t d;
  logic request;
  logic run;
  logic xfer_done;
  logic block_end;
  logic set_tc;
  logic set_ovr;
  logic [15:0] len_next;
  logic [7:0] status;
  logic m2m;

  assign m2m = q.ctrl.memory_to_memory_select;
  assign request = hw_request_line | q.ctrl.soft_request;
  assign channel_busy = q.ctrl.channel_on && (q.len_cnt != 16'h0000);
  assign run = channel_busy && request && !debug_halt;

  always_comb
  begin
    status = 8'h00;
    status[DMARC_ST_TC_BIT] = q.tc;
    status[DMARC_ST_OVR_BIT] = q.overrun_flag;
    status[DMARC_ST_BUSY_BIT] = channel_busy;
    status[DMARC_ST_VLD_BIT] = q.vld;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    d = q;
    xfer_done = 1'b0;
    block_end = 1'b0;
    set_tc = 1'b0;
    set_ovr = 1'b0;
    len_next = q.len_cnt;

    // transfer engine
    unique case (q.ph)
      DMARC_IDLE:
      begin
        if (run)
        begin
          d.ph = DMARC_FIRST;
          d.mem.req = 1'b1;
          d.mem.word = q.ctrl.unit_size_select;
          if (m2m)
          begin
            d.mem.we = 1'b0;
            d.mem.addr = q.ctrl.a_side_is_target ? q.b_cnt : q.a_cnt;
          end
          else
          begin
            d.mem.we = q.ctrl.a_side_is_target;
            d.mem.addr = q.a_cnt;
          end
        end
      end
      DMARC_FIRST:
      begin
        if (mem_rsp.ack)
        begin
          if (m2m)
          begin
            d.ph = DMARC_SECOND;
            d.mem.we = 1'b1;
            d.mem.wdata = mem_rsp.rdata;
            d.mem.addr = q.ctrl.a_side_is_target ? q.a_cnt : q.b_cnt;
          end
          else
          begin
            xfer_done = 1'b1;
          end
        end
      end
      DMARC_SECOND:
      begin
        if (mem_rsp.ack)
        begin
          xfer_done = 1'b1;
        end
      end
      default:
      begin
        d.ph = DMARC_IDLE;
        d.mem.req = 1'b0;
      end
    endcase

    // completed transfer: bus released, A pointer stepped (B pointer only in memory-to-memory mode), length counted
    if (xfer_done)
    begin
      d.ph = DMARC_IDLE;
      d.mem.req = 1'b0;
      d.mem.we = 1'b0;
      d.a_cnt = step_addr(q.a_cnt, q.ctrl.a_pointer_step_enable, q.ctrl.a_step_code);
      if (m2m)
      begin
        d.b_cnt = step_addr(q.b_cnt, q.ctrl.b_pointer_step_enable,
                            q.ctrl.b_step_code);
      end
      len_next = q.len_cnt - 16'h0001;
      d.len_cnt = len_next;
      block_end = (len_next == 16'h0000);
    end

    // block end handling
    if (block_end)
    begin
      set_tc = 1'b1;
      if (q.ctrl.reload_mode_select)
      begin
        d.a_cnt = q.a_rld;
        if (m2m)
        begin
          d.b_cnt = q.b_rld;
        end
        d.len_cnt = len_load(q.len_rld);
        set_ovr = q.tc;
      end
      else if (q.vld)
      begin
        d.a_cnt = q.a_rld;
        if (m2m)
        begin
          d.b_cnt = q.b_rld;
        end
        d.len_cnt = len_load(q.len_rld);
        d.vld = 1'b0;
      end
      else
      begin
        set_ovr = 1'b1;
      end
    end

    // software writes override the engine on data registers
    if (reg_hit(reg_req, DMARC_OFS_A_CNT))
    begin
      d.a_cnt = reg_req.wdata[23:0];
    end
    if (reg_hit(reg_req, DMARC_OFS_A_RLD))
    begin
      d.a_rld = reg_req.wdata[23:0];
    end
    if (reg_hit(reg_req, DMARC_OFS_B_CNT))
    begin
      d.b_cnt = reg_req.wdata[23:0];
    end
    if (reg_hit(reg_req, DMARC_OFS_B_RLD))
    begin
      d.b_rld = reg_req.wdata[23:0];
    end
    if (reg_hit(reg_req, DMARC_OFS_L_CNT))
    begin
      d.len_cnt = reg_req.wdata[15:0];
    end
    if (reg_hit(reg_req, DMARC_OFS_CTRL))
    begin
      d.ctrl = dmarc_ctrl_t'(reg_req.wdata[15:0] & DMARC_CTRL_WMASK);
      if (reg_req.wdata[0] && (d.len_cnt == 16'h0000))
      begin
        d.len_cnt = DMARC_LEN_ZERO_AS;
      end
    end
    if (reg_hit(reg_req, DMARC_OFS_STAT))
    begin
      if (reg_req.wdata[DMARC_ST_TC_BIT])
      begin
        d.tc = 1'b0;
      end
      if (reg_req.wdata[DMARC_ST_OVR_BIT])
      begin
        d.overrun_flag = 1'b0;
      end
      if (reg_req.wdata[DMARC_ST_VLD_BIT])
      begin
        d.vld = 1'b0;
      end
    end
    if (reg_hit(reg_req, DMARC_OFS_L_RLD))
    begin
      d.len_rld = reg_req.wdata[15:0];
      d.vld = 1'b1;
    end

    // hardware sets win over software clears
    if (set_tc)
    begin
      d.tc = 1'b1;
    end
    if (set_ovr)
    begin
      d.overrun_flag = 1'b1;
    end

    // read data, valid only in the cycle after the strobe
    d.rdata = 32'h00000000;
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        DMARC_OFS_A_CNT: d.rdata = {8'h00, q.a_cnt};
        DMARC_OFS_A_RLD: d.rdata = {8'h00, q.a_rld};
        DMARC_OFS_B_CNT: d.rdata = {8'h00, q.b_cnt};
        DMARC_OFS_B_RLD: d.rdata = {8'h00, q.b_rld};
        DMARC_OFS_L_CNT: d.rdata = {16'h0000, q.len_cnt};
        DMARC_OFS_L_RLD: d.rdata = {16'h0000, q.len_rld};
        DMARC_OFS_CTRL: d.rdata = {16'h0000, q.ctrl};
        DMARC_OFS_STAT: d.rdata = {24'h000000, status};
        default: d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
      q.ph <= DMARC_IDLE;
      q.ctrl <= dmarc_ctrl_t'(DMARC_CTRL_RST);
      q.a_cnt <= DMARC_ADDR_RST;
      q.len_cnt <= DMARC_LEN_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata = q.rdata;
  assign mem_out = q.mem;
  assign mem_hold = q.ctrl.burst_select && channel_busy && request;
  assign chan_irq = (q.tc && q.ctrl.count_done_irq_enable)
                  || (q.overrun_flag && q.ctrl.overrun_irq_enable);
  assign dma_clk_en = q.ctrl.channel_on || other_channels_on;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic addr_read;
  assign addr_read = reg_req.rd && (reg_req.addr == DMARC_OFS_A_CNT
                     || reg_req.addr == DMARC_OFS_B_RLD);

  property p_addr_upper;
    addr_read |=> (reg_rdata[31:24] == 8'h00);
  endproperty
  a_addr_upper: assert property (p_addr_upper) else $error("address upper bits not zero");

  sequence s_flyby_launch;
    (q.ph == DMARC_IDLE) && run && !m2m;
  endsequence
  property p_flyby_dir;
    s_flyby_launch |=> mem_out.req && (mem_out.we == $past(q.ctrl.a_side_is_target))
                       && (mem_out.addr == $past(q.a_cnt));
  endproperty
  a_flyby_dir: assert property (p_flyby_dir) else $error("flyby direction wrong");

  property p_a_step;
    xfer_done && !block_end && !reg_req.wr && q.ctrl.a_pointer_step_enable
      && (q.ctrl.a_step_code == DMARC_STEP_DEC2) |=> (q.a_cnt == $past(q.a_cnt) - 24'h000002);
  endproperty
  a_a_step: assert property (p_a_step) else $error("side A step wrong");

  property p_b_idle_flyby;
    xfer_done && !m2m && !reg_req.wr |=> $stable(q.b_cnt);
  endproperty
  a_b_idle_flyby: assert property (p_b_idle_flyby) else $error("side B moved in flyby");

  property p_len_dec;
    xfer_done && !block_end && !reg_req.wr |=> (q.len_cnt == $past(q.len_cnt) - 16'h0001);
  endproperty
  a_len_dec: assert property (p_len_dec) else $error("length not decremented");

  property p_vld_set;
    reg_hit(reg_req, DMARC_OFS_L_RLD) |=> q.vld;
  endproperty
  a_vld_set: assert property (p_vld_set) else $error("ready flag not set");

  property p_tc_sticky;
    q.tc && !reg_hit(reg_req, DMARC_OFS_STAT) |=> q.tc;
  endproperty
  a_tc_sticky: assert property (p_tc_sticky) else $error("done flag lost");

  property p_done_at_end;
    block_end |=> q.tc ##0 chan_irq == q.ctrl.count_done_irq_enable || q.overrun_flag;
  endproperty
  a_done_at_end: assert property (p_done_at_end) else $error("done flag missing");

  property p_overrun_single;
    block_end && !q.ctrl.reload_mode_select && !q.vld && !reg_req.wr
      |=> q.overrun_flag && !channel_busy;
  endproperty
  a_overrun_single: assert property (p_overrun_single) else $error("no overrun stop");

  property p_halt_idle;
    debug_halt && (q.ph == DMARC_IDLE) |=> (q.ph == DMARC_IDLE) && !mem_out.req;
  endproperty
  a_halt_idle: assert property (p_halt_idle) else $error("transfer under halt");

  property p_busy_read;
    reg_req.rd && (reg_req.addr == DMARC_OFS_STAT)
      |=> reg_rdata[DMARC_ST_BUSY_BIT] == $past(channel_busy);
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy bit wrong");

  sequence s_m2m_read_done;
    (q.ph == DMARC_FIRST) && m2m && mem_rsp.ack;
  endsequence
  property p_m2m_write;
    s_m2m_read_done |=> mem_out.req && mem_out.we
                        && (mem_out.wdata == $past(mem_rsp.rdata));
  endproperty
  a_m2m_write: assert property (p_m2m_write) else $error("copy write step wrong");

  property p_buffer_reload;
    block_end && !q.ctrl.reload_mode_select && q.vld && !reg_req.wr
      |=> !q.vld && (q.a_cnt == $past(q.a_rld)) && (q.len_cnt == len_load($past(q.len_rld)));
  endproperty
  a_buffer_reload: assert property (p_buffer_reload) else $error("reload missed");

  property p_auto_reload;
    block_end && q.ctrl.reload_mode_select && !reg_req.wr
      |=> (q.a_cnt == $past(q.a_rld)) && (q.len_cnt == len_load($past(q.len_rld)));
  endproperty
  a_auto_reload: assert property (p_auto_reload) else $error("auto reload missed");

endmodule : dmarc_channel

`default_nettype wire

// ===== verilog/dmarc_pkg.sv
// dmarc_pkg: constants and types for one dma channel with register control
package dmarc_pkg;

  // register offsets
  localparam logic [7:0] DMARC_OFS_A_CNT = 8'h00;
  localparam logic [7:0] DMARC_OFS_A_RLD = 8'h04;
  localparam logic [7:0] DMARC_OFS_B_CNT = 8'h08;
  localparam logic [7:0] DMARC_OFS_B_RLD = 8'h0C;
  localparam logic [7:0] DMARC_OFS_L_CNT = 8'h10;
  localparam logic [7:0] DMARC_OFS_L_RLD = 8'h14;
  localparam logic [7:0] DMARC_OFS_CTRL = 8'h1C;
  localparam logic [7:0] DMARC_OFS_STAT = 8'h1E;

  // status bit positions
  localparam int DMARC_ST_TC_BIT = 0;
  localparam int DMARC_ST_OVR_BIT = 1;
  localparam int DMARC_ST_BUSY_BIT = 2;
  localparam int DMARC_ST_VLD_BIT = 3;

  // reset values and masks
  localparam logic [15:0] DMARC_CTRL_RST = 16'h0000;
  localparam logic [15:0] DMARC_CTRL_WMASK = 16'h7FFF;
  localparam logic [23:0] DMARC_ADDR_RST = 24'h000000;
  localparam logic [15:0] DMARC_LEN_RST = 16'h0000;
  localparam logic [15:0] DMARC_LEN_ZERO_AS = 16'hFFFF;

  // step codes
  localparam logic [1:0] DMARC_STEP_INC1 = 2'h0;
  localparam logic [1:0] DMARC_STEP_INC2 = 2'h1;
  localparam logic [1:0] DMARC_STEP_DEC1 = 2'h2;
  localparam logic [1:0] DMARC_STEP_DEC2 = 2'h3;

  typedef enum logic [1:0] {DMARC_IDLE, DMARC_FIRST, DMARC_SECOND} dmarc_phase_t;

  typedef struct packed {
    logic reserved;
    logic [1:0] b_step_code;
    logic b_pointer_step_enable;
    logic [1:0] a_step_code;
    logic a_pointer_step_enable;
    logic soft_request;
    logic burst_select;
    logic reload_mode_select;
    logic a_side_is_target;
    logic memory_to_memory_select;
    logic unit_size_select;
    logic overrun_irq_enable;
    logic count_done_irq_enable;
    logic channel_on;
  } dmarc_ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dmarc_regreq_t;

  typedef struct packed {
    logic req;
    logic we;
    logic word;
    logic [23:0] addr;
    logic [15:0] wdata;
  } dmarc_memreq_t;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } dmarc_memrsp_t;

  typedef struct packed {
    dmarc_phase_t ph;
    logic [23:0] a_cnt;
    logic [23:0] a_rld;
    logic [23:0] b_cnt;
    logic [23:0] b_rld;
    logic [15:0] len_cnt;
    logic [15:0] len_rld;
    dmarc_ctrl_t ctrl;
    logic tc;
    logic overrun_flag;
    logic vld;
    dmarc_memreq_t mem;
    logic [31:0] rdata;
  } dmarc_state_t;

endpackage : dmarc_pkg
